// ---- src/awm_pkg.sv ----
/*
 * constants, types and register map of the amplifier watchdog monitor.
 * assumes a 100 MHz clock and an 8-bit register port with byte-wide registers.
 */
//
// Contract
// - supervision runs only while the enable bit is 1, which is its value after reset.
// - a timeout is declared when no kick edge comes within 5, 20, 35 or 50 ms, as the interval select picks.
// - rising and falling kick pin edges both count as valid edges.
// - action 00 neither mutes nor shuts down and leaves the boost voltage alone.
// - action 01 shuts the amplifier down to high impedance and sends the boost to bypass.
// - action 10 mutes, instantly or by soft ramp, and sends the boost to bypass.
// - action 11 applies the fallback gain code instead of the normal gain code.
// - the soft mute steps 0.5 dB per 1 to 64 samples, code 000 meaning no ramp.
package awm_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h20;
  localparam logic [7:0] ADDR_FBG  = 8'h21;
  localparam logic [7:0] ADDR_STS  = 8'h22;
  localparam logic [7:0] ADDR_MASK = 8'h23;

  localparam int unsigned EN_BIT   = 7;
  localparam int unsigned SEL_LSB  = 4;
  localparam int unsigned RESP_LSB = 0;
  localparam int unsigned STS_TMO  = 0;
  localparam int unsigned STS_LIVE = 7;

  localparam logic       RST_EN   = 1'b1;
  localparam logic [1:0] RST_SEL  = 2'h2;
  localparam logic [1:0] RST_RESP = 2'h2;
  localparam logic [7:0] RST_FBG  = 8'h28;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] GAIN_MUTE = 8'hFF;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_IV0_US = 5000;
  localparam int unsigned T_IV1_US = 20000;
  localparam int unsigned T_IV2_US = 35000;
  localparam int unsigned T_IV3_US = 50000;
  localparam int unsigned CNT_W    = 23;
  localparam int unsigned DIV_W    = 7;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    AWM_IDLE  = 2'b00,
    AWM_WATCH = 2'b01,
    AWM_TRIP  = 2'b11
  } awm_state_e;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_SHUT = 2'b01,
    ACT_MUTE = 2'b10,
    ACT_FALL = 2'b11
  } awm_resp_e;

  typedef struct packed {
    logic amp_hiz;
    logic boost_bypass;
    logic mute;
    logic fallback;
  } awm_action_s;

endpackage

// ---- src/awm_watchdog.sv ----
/*
 * watchdog monitor: supervises the kick pin and applies the timeout action.
 * assumes kick_input_pin_i is asynchronous; all other inputs share clk_i.
 */
`timescale 1ns/100ps
module awm_watchdog import awm_pkg::*; #(
  parameter int unsigned IV0_CYC = T_IV0_US * 1000 / CLK_PERIOD_NS,
  parameter int unsigned IV1_CYC = T_IV1_US * 1000 / CLK_PERIOD_NS,
  parameter int unsigned IV2_CYC = T_IV2_US * 1000 / CLK_PERIOD_NS,
  parameter int unsigned IV3_CYC = T_IV3_US * 1000 / CLK_PERIOD_NS
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        kick_input_pin_i,
  input  wire logic [2:0]  gain_ramp_setting_i,
  input  wire logic        sample_tick_i,
  input  wire logic [7:0]  volume_code_i,
  output awm_action_s      action_o,
  output logic      [7:0]  gain_code_o,
  output logic             irq_o
);

  // ****************************************
  // functions
  // ****************************************
  // last count value of the selected interval
  function automatic logic [CNT_W-1:0] lim_of(input logic [1:0] s);
    int unsigned c;
    unique case (s)
      2'h0: c = IV0_CYC;
      2'h1: c = IV1_CYC;
      2'h2: c = IV2_CYC;
      2'h3: c = IV3_CYC;
    endcase
    return CNT_W'(c - 1);
  endfunction

  // samples per soft mute step, less one
  function automatic logic [DIV_W-1:0] div_of(input logic [2:0] r);
    return (r == 3'h0) ? '0 : DIV_W'((1 << (r - 3'h1)) - 1);
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic             en_q;
  logic [1:0]       sel_q;
  logic [1:0]       resp_q;
  logic [7:0]       fbg_q;
  logic [7:0]       mask_q;
  logic [7:0]       sts_q;
  logic [7:0]       rdata_q;
  logic             en_prev_q;
  logic [2:0]       kick_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DIV_W-1:0] div_q;
  logic [7:0]       mgain_q;
  logic [7:0]       gain_q;
  awm_action_s      act_q;
  awm_state_e       state_q;
  awm_state_e       state_d;

  logic wr_ctrl;
  logic kick_edge;
  logic restart;
  logic expire;
  logic trip_evt;
  logic tripped;

  assign wr_ctrl   = wr_i && (addr_i == ADDR_CTRL);
  // either direction of the pin is a kick
  assign kick_edge = kick_q[2] ^ kick_q[1];
  assign restart   = kick_edge || (en_q && !en_prev_q);
  // at or past the limit, so a shorter interval written mid-count still trips
  assign expire    = (cnt_q >= lim_of(sel_q)) && !restart;
  assign trip_evt  = (state_q == AWM_WATCH) && expire;
  assign tripped   = (state_q == AWM_TRIP);

  // control register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      en_q   <= RST_EN;
      sel_q  <= RST_SEL;
      resp_q <= RST_RESP;
    end else if (wr_ctrl) begin
      en_q   <= wdata_i[EN_BIT];
      sel_q  <= wdata_i[SEL_LSB +: 2];
      resp_q <= wdata_i[RESP_LSB +: 2];
    end
  end

  // fallback gain and mask registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fbg_q  <= RST_FBG;
      mask_q <= RST_MASK;
    end else if (wr_i) begin
      if (addr_i == ADDR_FBG) begin
        fbg_q <= wdata_i;
      end
      if (addr_i == ADDR_MASK) begin
        mask_q <= wdata_i & 8'h01;
      end
    end
  end

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sts_q <= 8'h00;
    end else begin
      sts_q[STS_TMO] <= trip_evt ||
        (sts_q[STS_TMO] && !(wr_i && addr_i == ADDR_STS && wdata_i[STS_TMO]));
    end
  end

  assign irq_o = |(sts_q & mask_q);

  // read data, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        ADDR_CTRL: rdata_q <= {en_q, 1'b0, sel_q, 2'b00, resp_q};
        ADDR_FBG:  rdata_q <= fbg_q;
        ADDR_STS:  rdata_q <= {tripped, 6'h00, sts_q[STS_TMO]};
        ADDR_MASK: rdata_q <= mask_q;
        default:   rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_o = rdata_q;

  // ****************************************
  // kick pin and interval counter
  // ****************************************
  // two-stage synchroniser plus edge history
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      kick_q    <= 3'h0;
      en_prev_q <= 1'b0;
    end else begin
      kick_q    <= {kick_q[1:0], kick_input_pin_i};
      en_prev_q <= en_q;
    end
  end

  // interval counter, measured from the latest edge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else if (state_q != AWM_WATCH || restart) begin
      cnt_q <= '0;
    end else if (!expire) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // supervision state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      AWM_IDLE:  if (en_q) state_d = AWM_WATCH;
      AWM_WATCH: if (expire) state_d = AWM_TRIP;
      AWM_TRIP:  if (kick_edge) state_d = AWM_WATCH;
      default:   state_d = AWM_IDLE;
    endcase
    if (!en_q) begin
      state_d = AWM_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= AWM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // timeout actions
  // ****************************************
  // action levels held while tripped
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      act_q <= '0;
    end else begin
      act_q.amp_hiz      <= tripped && resp_q == ACT_SHUT;
      act_q.boost_bypass <= tripped && (resp_q == ACT_SHUT || resp_q == ACT_MUTE);
      act_q.mute         <= tripped && resp_q == ACT_MUTE;
      act_q.fallback     <= tripped && resp_q == ACT_FALL;
    end
  end

  assign action_o = act_q;

  // soft mute ramp, one step per 2^(n-1) samples
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !(tripped && resp_q == ACT_MUTE)) begin
      div_q   <= '0;
      mgain_q <= (gain_ramp_setting_i == 3'h0) ? GAIN_MUTE : volume_code_i;
    end else if (sample_tick_i && mgain_q != GAIN_MUTE) begin
      if (div_q == div_of(gain_ramp_setting_i)) begin
        div_q   <= '0;
        mgain_q <= mgain_q + 8'h01;
      end else begin
        div_q <= div_q + DIV_W'(1);
      end
    end
  end

  // gain code handed to the volume path
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gain_q <= 8'h00;
    end else if (act_q.fallback) begin
      gain_q <= fbg_q;
    end else if (act_q.mute) begin
      gain_q <= mgain_q;
    end else begin
      gain_q <= volume_code_i;
    end
  end

  assign gain_code_o = gain_q;

  // ****************************************
  // checks
  // ****************************************
  sequence s_trip;
    state_q == AWM_WATCH ##1 state_q == AWM_TRIP;
  endsequence

  sequence s_trip_mute;
    s_trip ##0 resp_q == ACT_MUTE ##0 gain_ramp_setting_i == 3'h0;
  endsequence

  chk_disable_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !en_q |=> state_q == AWM_IDLE)
    else $error("supervision still active while disabled");

  chk_expire_trip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == AWM_WATCH && en_q && cnt_q == lim_of(sel_q) && !restart |=> state_q == AWM_TRIP)
    else $error("interval expiry did not trip");

  chk_edge_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_q == AWM_WATCH && en_q && $changed(kick_q[2]) |-> cnt_q == '0)
    else $error("kick edge did not restart the interval");

  chk_trip_status: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_trip |-> sts_q[STS_TMO])
    else $error("timeout not recorded in status");

  chk_none_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tripped && resp_q == ACT_NONE && $stable(resp_q) |=> act_q == '0)
    else $error("action 00 drove an action");

  chk_shut_hiz: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tripped && resp_q == ACT_SHUT |=> act_q.amp_hiz && act_q.boost_bypass && !act_q.mute)
    else $error("shutdown action incomplete");

  chk_mute_bypass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tripped && resp_q == ACT_MUTE |=> act_q.mute && act_q.boost_bypass && !act_q.amp_hiz)
    else $error("mute action incomplete");

  chk_fallback_gain: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    act_q.fallback |=> gain_q == $past(fbg_q))
    else $error("fallback gain not applied");

  chk_instant_mute: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_trip_mute ##0 $stable(gain_ramp_setting_i) |=> ##1 gain_q == GAIN_MUTE)
    else $error("instant mute not applied");

  chk_fbg_reset: assert property (@(posedge clk_i)
    sys_rst_i |=> fbg_q == RST_FBG)
    else $error("fallback gain reset code wrong");

  chk_enable_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    en_q && !en_prev_q |=> cnt_q == '0)
    else $error("enable did not restart the interval");

  chk_sticky_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sts_q[STS_TMO] && !(wr_i && addr_i == ADDR_STS && wdata_i[STS_TMO]) |=> sts_q[STS_TMO])
    else $error("timeout status lost without a clear");

  chk_idle_gain: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    act_q == '0 |=> gain_q == $past(volume_code_i))
    else $error("gain code left the normal volume without an action");

  chk_ramp_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tripped && resp_q == ACT_MUTE && !sample_tick_i |=> $stable(mgain_q))
    else $error("mute ramp moved without a sample");

  chk_ramp_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tripped && resp_q == ACT_MUTE |=> mgain_q == $past(mgain_q) || mgain_q == $past(mgain_q) + 8'h01)
    else $error("mute ramp step larger than one code");

endmodule

// ---- test/awm_kick_model.sv ----
/*
 * kick pin model of the application processor.
 * assumes run_i and half_i are changed by the bench between clock edges.
 */
`timescale 1ns/100ps
module awm_kick_model (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  output logic            kick_o
);
  logic [7:0] cnt_q;
  logic       wrap;

  // ****************************************
  // kick generation
  // ****************************************
  assign wrap = (cnt_q == half_i - 8'h01);

  // cycle counter, held at zero while stopped
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !run_i) begin
      cnt_q <= 8'h00;
    end else if (wrap) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // one level change per half_i cycles, rising and falling alike
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      kick_o <= 1'b0;
    end else if (run_i && wrap) begin
      kick_o <= ~kick_o;
    end
  end
endmodule

// ---- test/amp_watchdog_monitor_bench.sv ----
/*
 * self-checking bench of the amplifier watchdog monitor.
 * assumes shortened intervals of 50, 100, 150 and 200 cycles.
 */
`timescale 1ns/100ps
module amp_watchdog_monitor_bench import awm_pkg::*;;
  logic        clk_i, sys_rst_i, wr_i, rd_i, sample_tick_i, irq_o;
  logic        kick_input_pin_i, kick_run;
  logic [7:0]  addr_i, wdata_i, rdata_o, volume_code_i, gain_code_o, kick_half;
  logic [2:0]  gain_ramp_setting_i;
  awm_action_s action_o;
  int          fail_count, comparisons, cycles;
  localparam logic [3:0] ACT_EXP [4] = '{4'h0, 4'hC, 4'h6, 4'h1};
  localparam logic [7:0] GAIN_EXP [4] = '{8'h30, 8'h00, GAIN_MUTE, 8'h50};

  // ****************************************
  // design, partner and clocking
  // ****************************************
  awm_watchdog #(.IV0_CYC(50), .IV1_CYC(100), .IV2_CYC(150), .IV3_CYC(200)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .kick_input_pin_i(kick_input_pin_i),
    .gain_ramp_setting_i(gain_ramp_setting_i), .sample_tick_i(sample_tick_i),
    .volume_code_i(volume_code_i), .action_o(action_o), .gain_code_o(gain_code_o), .irq_o(irq_o)
  );

  awm_kick_model u_kick (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .run_i(kick_run), .half_i(kick_half),
    .kick_o(kick_input_pin_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // sample tick every fourth cycle and the hang limit
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    sample_tick_i <= (cycles % 4 == 0);
    if (cycles == 4000) begin
      fail_count++;
      end_sim();
    end
  end

  // ****************************************
  // access tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // disable, clear the sticky flag, then enable with a new setting
  task automatic restart(input logic [7:0] ctrl);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_STS, 8'h01);
    wr(ADDR_CTRL, ctrl);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    fail_count = 0;
    comparisons = 0;
    sys_rst_i = 1'b1;
    {wr_i, rd_i, kick_run} = 3'h0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    volume_code_i = 8'h30;
    gain_ramp_setting_i = 3'b000;
    kick_half = 8'h1E;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // reset values, reserved bits and an unmapped address
    rdc(ADDR_CTRL, 8'hA2);
    // read data falls back to zero one cycle later
    cyc(1);
    chk(rdata_o, 8'h00);
    rdc(ADDR_FBG, RST_FBG);
    rdc(ADDR_STS, 8'h00);
    rdc(ADDR_MASK, RST_MASK);
    wr(ADDR_FBG, 8'h50);
    rdc(ADDR_FBG, 8'h50);
    wr(ADDR_CTRL, 8'hFF);
    rdc(ADDR_CTRL, 8'hB3);
    wr(8'h30, 8'hFF);
    rdc(8'h30, 8'h00);
    $display("test registers done");
    // kicks 30 cycles apart on alternate edges keep a 50 cycle interval quiet
    kick_run <= 1'b1;
    restart(8'h81);
    cyc(400);
    chk({4'h0, action_o}, 8'h00);
    rdc(ADDR_STS, 8'h00);
    kick_run <= 1'b0;
    $display("test kicks done");
    // each interval code paired with the same action code
    wr(ADDR_MASK, 8'h01);
    for (int i = 0; i < 4; i++) begin
      restart({2'b10, i[1:0], 2'b00, i[1:0]});
      cyc(50 * i + 46);
      chk({3'h0, irq_o, action_o}, 8'h00);
      cyc(8);
      chk({3'h0, irq_o, action_o}, {4'h1, ACT_EXP[i]});
      if (i != 1) chk(gain_code_o, GAIN_EXP[i]);
      rdc(ADDR_STS, 8'h81);
    end
    $display("test timeouts done");
    // masked interrupt, then supervision off
    wr(ADDR_MASK, 8'h00);
    cyc(1);
    chk({7'h0, irq_o}, 8'h00);
    wr(ADDR_CTRL, 8'h22);
    wr(ADDR_STS, 8'h01);
    rdc(ADDR_STS, 8'h00);
    cyc(300);
    chk({4'h0, action_o}, 8'h00);
    rdc(ADDR_STS, 8'h00);
    $display("test disable done");
    // soft mute climbs one step a sample
    volume_code_i <= 8'hF0;
    gain_ramp_setting_i <= 3'b001;
    restart(8'h82);
    cyc(54);
    chk({4'h0, action_o}, 8'h06);
    chk({7'h0, gain_code_o >= 8'hF0 && gain_code_o < 8'hFF}, 8'h01);
    cyc(100);
    chk(gain_code_o, GAIN_MUTE);
    // the slowest ramp code holds the first step for 64 samples
    gain_ramp_setting_i <= 3'b111;
    restart(8'h82);
    cyc(154);
    chk(gain_code_o, 8'hF0);
    $display("test ramp done");
    // reset in mid-run, while tripped, returns outputs and registers to reset values
    sys_rst_i <= 1'b1;
    cyc(2);
    sys_rst_i <= 1'b0;
    chk({3'h0, irq_o, action_o}, 8'h00);
    rdc(ADDR_FBG, RST_FBG);
    rdc(ADDR_CTRL, 8'hA2);
    rdc(ADDR_STS, 8'h00);
    $display("test reset done");
    end_sim();
  end
endmodule
